// ==== inc/spmc_defines.svh ====
// register offsets, field positions, reset values and timing counts of the power-mode controller
`ifndef SPMC_DEFINES_SVH
`define SPMC_DEFINES_SVH

// register indices; printed offsets are not all multiples of four, byte address = 4 * index
`define SPMC_IDX_GLOBAL_PWR    8'h0e
`define SPMC_IDX_SLEEP_TIME    8'h0f
`define SPMC_IDX_PORT1_CTL13   8'h1d
`define SPMC_IDX_PORT2_CTL13   8'h2d
`define SPMC_IDX_PORT3_CTL13   8'h3d
`define SPMC_IDX_PORT4_CTL13   8'h4d
`define SPMC_IDX_PORT5_CTL13   8'h5d
`define SPMC_IDX_PHY_CTL0      8'h60
`define SPMC_IDX_STATUS        8'h61

`define SPMC_MODE_MSB          4
`define SPMC_MODE_LSB          3
`define SPMC_PORT_PD_BIT       3
`define SPMC_PHY_PD_BIT        11
`define SPMC_AN_EN_BIT         7

`define SPMC_RST_GLOBAL_PWR    8'h00
`define SPMC_RST_SLEEP_TIME    8'h50
`define SPMC_RST_CTL13         8'h00
`define SPMC_RST_PHY_CTL0      16'h0000

// pulse 120 ns at 125 MHz (8 ns): longest time rounds down -> 15 cycles
`define SPMC_PULSE_NS          120
`define SPMC_CLK_NS            8
`define SPMC_PULSE_CYC         (`SPMC_PULSE_NS / `SPMC_CLK_NS)
`define SPMC_SEC_CYC           125000000
`define SPMC_SLEEP_UNIT_CYC    125000000
`define SPMC_INT_RESET_CYC     16

`endif

// ==== inc/spmc_pkg.sv ====
// types of the power-mode controller
package spmc_pkg;

   typedef enum logic [1:0] {
      SPMC_MODE_NORMAL = 2'b00,
      SPMC_MODE_ENERGY = 2'b01,
      SPMC_MODE_SOFT_PD = 2'b10,
      SPMC_MODE_SAVING = 2'b11
   } spmc_mode_t;

   typedef enum logic [1:0] {
      SPMC_ED_AWAKE,
      SPMC_ED_ASLEEP
   } spmc_ed_t;

   typedef struct packed {
      logic       pll_on;
      logic       mac_on;
      logic       host_on;
      logic [4:0] phy_tx_on;
      logic [4:0] phy_rx_on;
      logic       sleeping;
   } spmc_pwr_t;

endpackage : spmc_pkg

// ==== core/spmc_top.sv ====
// power-mode controller of a five-port switch: modes, energy-detect sleep, per-port power-down
//
// What this block does
// - hold everything powered down while hw_power_down_n stays low.
// - on release of hw_power_down_n run an internal reset of the whole chip.
// - mode field bits 4:3 decode as normal, energy detect, soft power-down, saving.
// - mode field reads 00 after power-up or hardware reset.
// - normal mode keeps clocks, PHYs and MACs on; host may pick any mode.
// - energy detect without energy emits 120 ns pulses once per second.
// - energy detect sleeps after idle longer than the go-sleep time value.
// - asleep, everything is off except the receive energy detector.
// - energy seen while asleep returns to the normal power state.
// - soft power-down stops clocks and turns off every PHY and MAC.
// - any host access in soft power-down wakes to normal and resets registers.
// - power saving acts only with mode 11, autoneg on and cable absent.
// - power saving keeps clocks, MAC, registers and host interface alive.
// - power saving keeps PHY transmit on, turns off only the unused receiver.
// - link activity during power saving restores the PHY to normal power.
// - during power saving the host may write the mode field to any mode.
// - port control 13 bit 3 powers down that port's PHY alone.
// - PHY control 0 bit 11 also powers down port 1's PHY.
`timescale 1ns/1ps
`include "spmc_defines.svh"

module spmc_top #(
   parameter int SEC_CYC        = `SPMC_SEC_CYC,         // cycles in one second
   parameter int SLEEP_UNIT_CYC = `SPMC_SLEEP_UNIT_CYC,  // cycles per go-sleep step
   parameter int RST_CYC        = `SPMC_INT_RESET_CYC    // internal reset length
) (
   input  wire logic        clk,             // 125 MHz clock
   input  wire logic        resetn,          // synchronous reset, active low
   input  wire logic        hw_power_down_n, // power-down pin, active low, async
   input  wire logic [4:0]  cable_energy,    // per-port energy detector, async
   input  wire logic [4:0]  cable_present,   // per-port cable connected, async
   input  wire logic        psel,            // apb select
   input  wire logic        penable,         // apb enable
   input  wire logic        pwrite,          // apb direction
   input  wire logic [31:0] paddr,           // apb byte address
   input  wire logic [31:0] pwdata,          // apb write data
   output logic      [31:0] prdata,          // apb read data
   output logic             pready,          // apb ready
   output logic             pslverr,         // apb error, unmapped address
   output logic             pll_on,          // pll clocks enabled
   output logic             mac_on,          // macs enabled
   output logic             host_on,         // host interface enabled
   output logic      [4:0]  phy_tx_on,       // per-port phy transmitter on
   output logic      [4:0]  phy_rx_on,       // per-port phy receiver on
   output logic             detect_pulse,    // 120 ns link pulse while idle
   output logic             chip_reset       // internal chip reset
);

   // =====================================================================
   // state
   typedef struct packed {
      logic [1:0]          pd_sync;
      logic [1:0][4:0]     en_sync;
      logic [1:0][4:0]     cab_sync;
      logic [7:0]          gpwr;
      logic [7:0]          sleep_time;
      logic [4:0][7:0]     ctl13;
      logic [15:0]         phy_ctl0;
      spmc_pkg::spmc_ed_t  ed;
      logic [31:0]         idle_cnt;
      logic [7:0]          idle_units;
      logic [31:0]         sec_cnt;
      logic [7:0]          rst_cnt;
      logic                was_pd;
      logic [31:0]         prdata;
      logic                pready;
      logic                pslverr;
      spmc_pkg::spmc_pwr_t pwr;
      logic                pulse;
      logic                chip_reset;
   } spmc_state_t;

   spmc_state_t s;
   spmc_state_t next_s;

   function automatic logic [7:0] reg_index(input logic [31:0] a);
      reg_index = a[9:2];
   endfunction : reg_index

   function automatic logic [31:0] read_word(input spmc_state_t st, input logic [7:0] idx);
      read_word = 32'h0;
      if (idx == `SPMC_IDX_GLOBAL_PWR) begin
         read_word[7:0] = st.gpwr;
      end else if (idx == `SPMC_IDX_SLEEP_TIME) begin
         read_word[7:0] = st.sleep_time;
      end else if (idx == `SPMC_IDX_PORT1_CTL13) begin
         read_word[7:0] = st.ctl13[0];
      end else if (idx == `SPMC_IDX_PORT2_CTL13) begin
         read_word[7:0] = st.ctl13[1];
      end else if (idx == `SPMC_IDX_PORT3_CTL13) begin
         read_word[7:0] = st.ctl13[2];
      end else if (idx == `SPMC_IDX_PORT4_CTL13) begin
         read_word[7:0] = st.ctl13[3];
      end else if (idx == `SPMC_IDX_PORT5_CTL13) begin
         read_word[7:0] = st.ctl13[4];
      end else if (idx == `SPMC_IDX_PHY_CTL0) begin
         read_word[15:0] = st.phy_ctl0;
      end else if (idx == `SPMC_IDX_STATUS) begin
         read_word[0] = (st.ed == spmc_pkg::SPMC_ED_ASLEEP);
         read_word[5:1] = st.en_sync[1];
      end
   endfunction : read_word

   function automatic logic mapped(input logic [7:0] idx);
      mapped = (idx == `SPMC_IDX_GLOBAL_PWR) || (idx == `SPMC_IDX_SLEEP_TIME)
             || (idx == `SPMC_IDX_PORT1_CTL13) || (idx == `SPMC_IDX_PORT2_CTL13)
             || (idx == `SPMC_IDX_PORT3_CTL13) || (idx == `SPMC_IDX_PORT4_CTL13)
             || (idx == `SPMC_IDX_PORT5_CTL13) || (idx == `SPMC_IDX_PHY_CTL0)
             || (idx == `SPMC_IDX_STATUS);
   endfunction : mapped

   // =====================================================================
   // next state
   logic             pd_low;
   logic [4:0]       energy;
   logic [4:0]       cable;
   logic [7:0]       idx;
   logic             access;
   logic             soft_wake;
   logic             in_reset;
   logic [1:0]       mode;
   logic [4:0]       port_pd;
   logic             save_ok;

   always_comb begin
      next_s = s;
      // only the second synchroniser stage is read below
      next_s.pd_sync  = {s.pd_sync[0], hw_power_down_n};
      next_s.en_sync  = {s.en_sync[0], cable_energy};
      next_s.cab_sync = {s.cab_sync[0], cable_present};
      pd_low = !s.pd_sync[1];
      energy = s.en_sync[1];
      cable  = s.cab_sync[1];
      idx    = reg_index(paddr);
      access = psel && penable && !s.pready;
      mode   = s.gpwr[`SPMC_MODE_MSB:`SPMC_MODE_LSB];
      soft_wake = access && (mode == spmc_pkg::SPMC_MODE_SOFT_PD);
      in_reset  = (s.rst_cnt != 8'h00);

      // apb: one wait state, answer on the second access cycle
      next_s.pready  = access;
      next_s.pslverr = access && !mapped(idx);
      next_s.prdata  = (access && !pwrite) ? read_word(s, idx) : 32'h0;
      if (access && pwrite && !soft_wake) begin
         if (idx == `SPMC_IDX_GLOBAL_PWR) begin
            next_s.gpwr = pwdata[7:0];
         end else if (idx == `SPMC_IDX_SLEEP_TIME) begin
            next_s.sleep_time = pwdata[7:0];
         end else if (idx == `SPMC_IDX_PORT1_CTL13) begin
            next_s.ctl13[0] = pwdata[7:0];
         end else if (idx == `SPMC_IDX_PORT2_CTL13) begin
            next_s.ctl13[1] = pwdata[7:0];
         end else if (idx == `SPMC_IDX_PORT3_CTL13) begin
            next_s.ctl13[2] = pwdata[7:0];
         end else if (idx == `SPMC_IDX_PORT4_CTL13) begin
            next_s.ctl13[3] = pwdata[7:0];
         end else if (idx == `SPMC_IDX_PORT5_CTL13) begin
            next_s.ctl13[4] = pwdata[7:0];
         end else if (idx == `SPMC_IDX_PHY_CTL0) begin
            next_s.phy_ctl0 = pwdata[15:0];
         end
      end

      // energy detect sleep and wake
      next_s.sec_cnt = (s.sec_cnt >= 32'(SEC_CYC - 1)) ? 32'h0 : s.sec_cnt + 32'h1;
      if (mode != spmc_pkg::SPMC_MODE_ENERGY || energy != 5'h00) begin
         next_s.idle_cnt   = 32'h0;
         next_s.idle_units = 8'h00;
         next_s.ed         = spmc_pkg::SPMC_ED_AWAKE;
      end else begin
         case (s.ed)
            spmc_pkg::SPMC_ED_AWAKE: begin
               if (s.idle_cnt >= 32'(SLEEP_UNIT_CYC - 1)) begin
                  next_s.idle_cnt = 32'h0;
                  if (s.idle_units != 8'hff) begin
                     next_s.idle_units = s.idle_units + 8'h01;
                  end
               end else begin
                  next_s.idle_cnt = s.idle_cnt + 32'h1;
               end
               if (s.idle_units > s.sleep_time) begin
                  next_s.ed = spmc_pkg::SPMC_ED_ASLEEP;
               end
            end
            default: begin
               next_s.ed = spmc_pkg::SPMC_ED_ASLEEP;
            end
         endcase
      end
      // pulse high for the first cycles of each second
      // a pulse only starts at the top of a second, so entering the mode never gives a runt
      next_s.pulse = (mode == spmc_pkg::SPMC_MODE_ENERGY) && (energy == 5'h00)
                   && (s.sec_cnt < 32'(`SPMC_PULSE_CYC))
                   && (s.pulse || s.sec_cnt == 32'h0);

      // block power per mode
      port_pd = '0;
      for (int p = 0; p < 5; p++) begin
         port_pd[p] = s.ctl13[p][`SPMC_PORT_PD_BIT];
      end
      port_pd[0] = port_pd[0] | s.phy_ctl0[`SPMC_PHY_PD_BIT];
      save_ok = (mode == spmc_pkg::SPMC_MODE_SAVING)
              && s.ctl13[0][`SPMC_AN_EN_BIT];
      next_s.pwr.pll_on    = 1'b1;
      next_s.pwr.mac_on    = 1'b1;
      next_s.pwr.host_on   = 1'b1;
      next_s.pwr.sleeping  = 1'b0;
      next_s.pwr.phy_tx_on = ~port_pd;
      next_s.pwr.phy_rx_on = ~port_pd;
      case (mode)
         spmc_pkg::SPMC_MODE_ENERGY: begin
            if (s.ed == spmc_pkg::SPMC_ED_ASLEEP) begin
               next_s.pwr.pll_on    = 1'b0;
               next_s.pwr.mac_on    = 1'b0;
               next_s.pwr.host_on   = 1'b0;
               next_s.pwr.phy_tx_on = 5'h00;
               next_s.pwr.phy_rx_on = 5'h00;
               next_s.pwr.sleeping  = 1'b1;
            end
         end
         spmc_pkg::SPMC_MODE_SOFT_PD: begin
            next_s.pwr.pll_on    = 1'b0;
            next_s.pwr.mac_on    = 1'b0;
            next_s.pwr.phy_tx_on = 5'h00;
            next_s.pwr.phy_rx_on = 5'h00;
         end
         spmc_pkg::SPMC_MODE_SAVING: begin
            if (save_ok) begin
               // receiver off only where no cable and no link attempt
               next_s.pwr.phy_rx_on = ~port_pd & (cable | energy);
            end
         end
         default: begin
         end
      endcase

      // hardware power-down and internal reset
      next_s.was_pd = pd_low;
      if (pd_low) begin
         next_s.pwr.pll_on    = 1'b0;
         next_s.pwr.mac_on    = 1'b0;
         next_s.pwr.host_on   = 1'b0;
         next_s.pwr.phy_tx_on = 5'h00;
         next_s.pwr.phy_rx_on = 5'h00;
      end
      if ((s.was_pd && !pd_low) || soft_wake) begin
         next_s.rst_cnt = 8'(RST_CYC);
      end else if (in_reset) begin
         next_s.rst_cnt = s.rst_cnt - 8'h01;
      end
      next_s.chip_reset = pd_low || (next_s.rst_cnt != 8'h00);
      if (pd_low || next_s.rst_cnt != 8'h00) begin
         next_s.gpwr       = `SPMC_RST_GLOBAL_PWR;
         next_s.sleep_time = `SPMC_RST_SLEEP_TIME;
         next_s.ctl13      = {5{`SPMC_RST_CTL13}};
         next_s.phy_ctl0   = `SPMC_RST_PHY_CTL0;
         next_s.ed         = spmc_pkg::SPMC_ED_AWAKE;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s            <= '0;
         s.pd_sync    <= 2'b11;
         s.sleep_time <= `SPMC_RST_SLEEP_TIME;
         s.ed         <= spmc_pkg::SPMC_ED_AWAKE;
         s.pwr        <= '{1'b1, 1'b1, 1'b1, 5'h1f, 5'h1f, 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign prdata       = s.prdata;
   assign pready       = s.pready;
   assign pslverr      = s.pslverr;
   assign pll_on       = s.pwr.pll_on;
   assign mac_on       = s.pwr.mac_on;
   assign host_on      = s.pwr.host_on;
   assign phy_tx_on    = s.pwr.phy_tx_on;
   assign phy_rx_on    = s.pwr.phy_rx_on;
   assign detect_pulse = s.pulse;
   assign chip_reset   = s.chip_reset;

   // =====================================================================
   // checks
   a_pd_all_off: assert property (@(posedge clk) disable iff (!resetn)
      !s.pd_sync[1] |=> !pll_on && !mac_on && phy_tx_on == 5'h00)
      else $error("blocks on during hardware power-down");
   a_release_reset: assert property (@(posedge clk) disable iff (!resetn)
      s.was_pd && s.pd_sync[1] |=> chip_reset [*8])
      else $error("no internal reset after power-down release");
   a_reset_mode_zero: assert property (@(posedge clk) disable iff (!resetn)
      chip_reset |-> s.gpwr[4:3] == 2'b00)
      else $error("mode not normal during reset");
   a_soft_pd_off: assert property (@(posedge clk) disable iff (!resetn)
      s.gpwr[4:3] == 2'b10 && !chip_reset |=> !pll_on && phy_rx_on == 5'h00)
      else $error("soft power-down left blocks on");
   a_soft_wake: assert property (@(posedge clk) disable iff (!resetn)
      psel && penable && !pready && s.gpwr[4:3] == 2'b10 |=> chip_reset)
      else $error("host access did not wake soft power-down");
   a_pulse_width: assert property (@(posedge clk)
      disable iff (!resetn || s.en_sync[1] != 5'h00 || s.gpwr[4:3] != 2'b01)
      $rose(detect_pulse) |-> detect_pulse [*8] ##1 detect_pulse [*7] ##1 !detect_pulse)
      else $error("energy pulse width wrong");
   a_sleep_off: assert property (@(posedge clk) disable iff (!resetn)
      s.ed == spmc_pkg::SPMC_ED_ASLEEP && s.gpwr[4:3] == 2'b01 && s.pd_sync[1]
      |=> !pll_on && !host_on && phy_rx_on == 5'h00)
      else $error("blocks on while asleep");
   a_phy0_pd: assert property (@(posedge clk) disable iff (!resetn)
      s.phy_ctl0[11] |=> !phy_tx_on[0] && !phy_rx_on[0])
      else $error("phy control power-down ignored");
   a_save_rx_off: assert property (@(posedge clk) disable iff (!resetn)
      s.gpwr[4:3] == 2'b11 && s.ctl13[0][7] && !s.cab_sync[1][1] && !s.en_sync[1][1]
      && s.pd_sync[1] |=> !phy_rx_on[1] && pll_on && host_on)
      else $error("power saving left an idle receiver on");
   a_save_restore: assert property (@(posedge clk) disable iff (!resetn)
      s.gpwr[4:3] == 2'b11 && s.ctl13[0][7] && s.cab_sync[1][2] && !s.ctl13[2][3]
      && s.pd_sync[1] |=> phy_rx_on[2])
      else $error("receiver not restored on link activity");
   a_wake_energy: assert property (@(posedge clk) disable iff (!resetn)
      s.ed == spmc_pkg::SPMC_ED_ASLEEP && s.en_sync[1] != 5'h00
      |=> s.ed == spmc_pkg::SPMC_ED_AWAKE)
      else $error("energy did not wake the device");
   a_idle_restart: assert property (@(posedge clk) disable iff (!resetn)
      s.en_sync[1] != 5'h00 |=> s.idle_units == 8'h00)
      else $error("idle timer not restarted by energy");
   a_save_tx_on: assert property (@(posedge clk) disable iff (!resetn)
      s.gpwr[4:3] == 2'b11 && s.ctl13 == '0 && !chip_reset && s.pd_sync[1]
      |=> phy_tx_on == 5'h1f && pll_on)
      else $error("power saving dropped transmit or clocks");
   a_port_pd: assert property (@(posedge clk) disable iff (!resetn)
      s.ctl13[2][3] |=> !phy_tx_on[2])
      else $error("port power-down ignored");
   c_sleep: cover property (@(posedge clk) disable iff (!resetn)
      s.ed == spmc_pkg::SPMC_ED_ASLEEP ##[1:20] s.ed == spmc_pkg::SPMC_ED_AWAKE);
   c_soft_wake: cover property (@(posedge clk) disable iff (!resetn)
      s.gpwr[4:3] == 2'b10 ##[1:20] chip_reset);
   c_hw_pd: cover property (@(posedge clk) disable iff (!resetn)
      !s.pd_sync[1] ##1 s.pd_sync[1]);
   c_saving: cover property (@(posedge clk) disable iff (!resetn)
      s.gpwr[4:3] == 2'b11 && s.ctl13[0][7] ##1 phy_rx_on != 5'h1f);
   c_pulse: cover property (@(posedge clk) disable iff (!resetn)
      $rose(detect_pulse));

endmodule : spmc_top

// ==== verification/spmc_link_partner.sv ====
// far end of the cable: attach state and line energy per port, prompt or slow
`timescale 1ns/1ps

module spmc_link_partner (
   input  wire logic       clk,           // bench clock
   input  wire logic [4:0] plug,          // cable attached per port
   input  wire logic [4:0] talk,          // far end trying to link per port
   input  wire logic       slow,          // energy onset three cycles late
   output logic      [4:0] cable_present, // attach level to the switch
   output logic      [4:0] cable_energy   // energy level to the switch
);
   logic [4:0] line [0:3] = '{default: 5'h00};

   // ========================================
   // line model
   // no cable means no energy, whatever the far end attempts
   always @(posedge clk) begin
      line[0] <= plug & talk;
      line[1] <= line[0];
      line[2] <= line[1];
      line[3] <= line[2];
   end

   always_comb begin
      cable_present = plug;
      cable_energy  = slow ? line[3] : line[0];
   end
endmodule : spmc_link_partner

// ==== verification/tb.sv ====
// self-checking bench of the power-mode controller
`timescale 1ns/1ps
`include "spmc_defines.svh"

module tb;
   localparam int SEC = 64;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        hw_power_down_n = 1'b1;
   logic [4:0]  plug = 5'h1f;
   logic [4:0]  talk = 5'h1f;
   logic        slow = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   wire  [4:0]  energy, present, phy_tx_on, phy_rx_on;
   wire  [31:0] prdata;
   wire         pready, pslverr, pll_on, mac_on, host_on, detect_pulse, chip_reset;
   wire  [12:0] pwr = {pll_on, mac_on, host_on, phy_tx_on, phy_rx_on};
   int          failures = 0;
   int          tests_run = 0;
   int          seed = 32'h1f1b1087;
   int          i, n, t, p;
   logic [31:0] rd, wd;
   logic        err;
   logic [4:0]  txe;

   always #4 clk = ~clk;

   spmc_top #(.SEC_CYC(SEC), .SLEEP_UNIT_CYC(4), .RST_CYC(16)) u_dut (
      .clk(clk), .resetn(resetn), .hw_power_down_n(hw_power_down_n),
      .cable_energy(energy), .cable_present(present), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pll_on(pll_on), .mac_on(mac_on), .host_on(host_on),
      .phy_tx_on(phy_tx_on), .phy_rx_on(phy_rx_on), .detect_pulse(detect_pulse),
      .chip_reset(chip_reset));

   spmc_link_partner u_partner (
      .clk(clk), .plug(plug), .talk(talk), .slow(slow),
      .cable_present(present), .cable_energy(energy));

   // ========================================
   // checking and bus tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic end_of_test;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test

   // request held until pready is sampled high; the wait is bounded, never assumed
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {22'h0, idx, 2'b00};
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) chk("pready", 32'h0, 32'h1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk($sformatf("reg %h", idx), rd, exp);
   endtask : rdc

   task automatic wait_pwr(input logic [12:0] exp, input logic [12:0] m);
      for (int k = 0; k < 60 && (pwr & m) !== (exp & m); k++) @(posedge clk);
      chk("power", 32'(pwr & m), 32'(exp & m));
   endtask : wait_pwr

   // ========================================
   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      end_of_test;
   end

   // ========================================
   // scenarios
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      rdc(`SPMC_IDX_GLOBAL_PWR, 32'h0);
      rdc(`SPMC_IDX_SLEEP_TIME, 32'h50);
      for (p = 0; p < 5; p++) rdc(8'h1d + 8'(p * 16), 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk("slverr", 32'(err), 32'h1);
      wait_pwr(13'h1fff, 13'h1fff);
      for (t = 0; t < 4; t++) if (t != 2) begin
         apb(1'b1, `SPMC_IDX_GLOBAL_PWR, 32'(t << 3));
         rdc(`SPMC_IDX_GLOBAL_PWR, 32'(t << 3));
      end
      // energy detect: an energy blip must restart the idle timer
      t = 2 + int'($unsigned($random(seed)) % 6);
      apb(1'b1, `SPMC_IDX_SLEEP_TIME, 32'(t));
      apb(1'b1, `SPMC_IDX_GLOBAL_PWR, 32'h08);
      talk <= 5'h00;
      repeat (t * 4 - 2) @(posedge clk);
      talk <= 5'h1f;
      repeat (3) @(posedge clk);
      talk <= 5'h00;
      repeat (t * 4) @(posedge clk);
      chk("awake", 32'(pll_on), 32'h1);
      wait_pwr(13'h0000, 13'h1fe0);
      n = 0;
      repeat (2 * SEC) begin
         @(posedge clk);
         if (detect_pulse === 1'b1) n++;
      end
      chk("pulse_cycles", 32'(n), 32'(2 * `SPMC_PULSE_CYC));
      slow <= 1'b1;
      talk <= 5'h1f;
      wait_pwr(13'h1fe0, 13'h1fe0);
      n = 0;
      repeat (SEC) begin
         @(posedge clk);
         if (detect_pulse === 1'b1) n++;
      end
      chk("pulse_quiet", 32'(n), 32'h0);
      slow <= 1'b0;
      apb(1'b1, `SPMC_IDX_GLOBAL_PWR, 32'h00);
      // soft power-down, woken by a dummy read
      apb(1'b1, `SPMC_IDX_SLEEP_TIME, 32'h33);
      apb(1'b1, `SPMC_IDX_GLOBAL_PWR, 32'h10);
      wait_pwr(13'h0400, 13'h1fff);
      apb(1'b0, `SPMC_IDX_GLOBAL_PWR, 32'h0);
      for (i = 0; i < 20 && chip_reset !== 1'b1; i++) @(posedge clk);
      chk("soft_wake", 32'(chip_reset), 32'h1);
      for (i = 0; i < 60 && chip_reset !== 1'b0; i++) @(posedge clk);
      rdc(`SPMC_IDX_GLOBAL_PWR, 32'h0);
      rdc(`SPMC_IDX_SLEEP_TIME, 32'h50);
      // power saving with every cable pulled, then the port 3 cable plugged back
      apb(1'b1, `SPMC_IDX_SLEEP_TIME, 32'h2a);
      plug <= 5'h00;
      talk <= 5'h00;
      apb(1'b1, `SPMC_IDX_PORT1_CTL13, 32'h80);
      apb(1'b1, `SPMC_IDX_GLOBAL_PWR, 32'h18);
      wait_pwr(13'h1fe0, 13'h1fff);
      rdc(`SPMC_IDX_SLEEP_TIME, 32'h2a);
      plug <= 5'h04;
      talk <= 5'h04;
      wait_pwr(13'h1fe4, 13'h1fff);
      apb(1'b1, `SPMC_IDX_PORT1_CTL13, 32'h00);
      wait_pwr(13'h1fff, 13'h1fff);
      apb(1'b1, `SPMC_IDX_GLOBAL_PWR, 32'h08);
      rdc(`SPMC_IDX_GLOBAL_PWR, 32'h08);
      apb(1'b1, `SPMC_IDX_GLOBAL_PWR, 32'h00);
      plug <= 5'h1f;
      talk <= 5'h1f;
      // per-port power-down with random control values, then PHY control 0 bit 11 on port 1
      for (t = 0; t < 6; t++) begin
         p = int'($unsigned($random(seed)) % 5);
         wd = $random(seed);
         txe = 5'h1f & ~(5'(wd[3]) << p);
         apb(1'b1, 8'h1d + 8'(p * 16), wd);
         wait_pwr({3'b111, txe, txe}, 13'h1fff);
         rdc(8'h1d + 8'(p * 16), {24'h0, wd[7:0]});
         apb(1'b1, 8'h1d + 8'(p * 16), 32'h0);
      end
      apb(1'b1, `SPMC_IDX_PHY_CTL0, 32'h800);
      wait_pwr(13'h1fde, 13'h1fff);
      rdc(`SPMC_IDX_PHY_CTL0, 32'h800);
      apb(1'b1, `SPMC_IDX_PHY_CTL0, 32'h0);
      // hardware power-down pin, then internal reset on release
      apb(1'b1, `SPMC_IDX_SLEEP_TIME, 32'h3c);
      hw_power_down_n <= 1'b0;
      wait_pwr(13'h0000, 13'h1fff);
      chk("pin_reset", 32'(chip_reset), 32'h1);
      hw_power_down_n <= 1'b1;
      n = 0;
      for (i = 0; i < 80 && chip_reset !== 1'b0; i++) begin
         @(posedge clk);
         n++;
      end
      chk("reset_len", 32'(n >= 16), 32'h1);
      rdc(`SPMC_IDX_SLEEP_TIME, 32'h50);
      wait_pwr(13'h1fff, 13'h1fff);
      end_of_test;
   end
endmodule : tb
